// ---- include/txp_pkg.sv ----
// constants, field layout and state type of the transmit command parser
// assumes a single 100 MHz clock and an AXI4-Lite register master
// Function
// - two 32-bit command words precede each buffer
// - packet edges come only from command bits
// - 16-bit tag copied into status word
// - differing B words in packet raise error
// - byte count versus packet length, error
// - bytes before start offset are discarded
// - later buffers start at own offset
// - end alignment padding accepted and removed
// - word A bit 31 flags buffer loaded
// - one status word per finished packet
// - status count reaching threshold signals host
// - overfilling the data FIFO raises error
// - alignment field 4, 16, 32 bytes
// - start offset in A bits 20:16
package txp_pkg;
    localparam int unsigned ADDR_W         = 8;
    // register byte offsets
    localparam logic [7:0]  REG_DATA_PORT  = 8'h00;
    localparam logic [7:0]  REG_SPACE_INFO = 8'h04;
    localparam logic [7:0]  REG_FLAGS      = 8'h08;
    localparam logic [7:0]  REG_STATUS_POP = 8'h0C;
    localparam logic [7:0]  REG_LEVEL      = 8'h10;
    // flag bits
    localparam int unsigned FLG_ERR        = 0;
    localparam int unsigned FLG_LOADED     = 1;
    localparam int unsigned FLG_LEVEL      = 2;
    // command word A fields
    localparam int unsigned A_IRQ          = 31;
    localparam int unsigned A_ALIGN_HI     = 25;
    localparam int unsigned A_ALIGN_LO     = 24;
    localparam int unsigned A_OFF_HI       = 20;
    localparam int unsigned A_OFF_LO       = 16;
    localparam int unsigned A_FIRST        = 13;
    localparam int unsigned A_LAST         = 12;
    localparam int unsigned A_SIZE_HI      = 10;
    // command word B fields
    localparam int unsigned B_TAG_HI       = 31;
    localparam int unsigned B_TAG_LO       = 16;
    localparam int unsigned B_LEN_HI       = 10;
    // alignment codes and masks
    localparam logic [1:0]  ALIGN_16       = 2'h1;
    localparam logic [1:0]  ALIGN_32       = 2'h2;
    localparam logic [11:0] MASK_4         = 12'h003;
    localparam logic [11:0] MASK_16        = 12'h00F;
    localparam logic [11:0] MASK_32        = 12'h01F;
    // queues
    localparam int unsigned DQ_DEPTH       = 16;
    localparam int unsigned DQ_AW          = 4;
    localparam int unsigned SQ_DEPTH       = 8;
    localparam int unsigned SQ_AW          = 3;
    // data queue entry: data, keep, last, tag, error
    localparam int unsigned E_KEEP_LO      = 32;
    localparam int unsigned E_LAST         = 36;
    localparam int unsigned E_TAG_LO       = 37;
    localparam int unsigned E_ERR          = 53;
    localparam int unsigned DQ_W           = 54;
    localparam int unsigned ST_ERR         = 15;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic [1:0] {
        PS_CMD_A,
        PS_CMD_B,
        PS_DATA
    } txp_parse_t;
endpackage : txp_pkg

// ---- rtl/txp_cmd_parser.sv ----
// transmit command parser: axi4-lite data port, command checks, stripping, status queue
// assumes host keeps the command order and a transmit engine draining tx_out_*
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module txp_cmd_parser
    import txp_pkg::*;
(
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite write address and data
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // stripped payload toward the transmit engine
    output logic                   tx_out_valid,
    input  wire logic              tx_out_ready,
    output logic [31:0]            tx_out_data,
    output logic [3:0]             tx_out_keep,
    output logic                   tx_out_last,
    // flags
    output logic                   tx_error_flag,
    output logic                   tx_buffer_loaded_flag,
    output logic                   tx_status_level_hit
);

    typedef struct packed {
        logic                             aw_have;
        logic [ADDR_W-1:0]                awaddr;
        logic                             w_have;
        logic [31:0]                      wdata;
        logic [3:0]                       wstrb;
        logic                             bvalid;
        logic [1:0]                       bresp;
        logic                             rvalid;
        logic [31:0]                      rdata;
        logic [1:0]                       rresp;
        txp_parse_t                       st;
        logic [31:0]                      cmd_a;
        logic [31:0]                      first_b;
        logic                             pkt_err;
        logic [11:0]                      pkt_bytes;
        logic [11:0]                      pos;
        logic [DQ_DEPTH-1:0][DQ_W-1:0]    dq;
        logic [DQ_AW:0]                   dq_cnt;
        logic [DQ_AW-1:0]                 dq_wr;
        logic [DQ_AW-1:0]                 dq_rd;
        logic [SQ_DEPTH-1:0][31:0]        sq;
        logic [SQ_AW:0]                   sq_cnt;
        logic [SQ_AW-1:0]                 sq_wr;
        logic [SQ_AW-1:0]                 sq_rd;
        logic                             err_flag;
        logic                             done_flag;
        logic [SQ_AW:0]                   level;
    } txp_regs_t;

    txp_regs_t q;
    txp_regs_t d;

    // bytes of the dword at pos that fall inside [off, stop)
    function automatic logic [3:0] txp_keep(input logic [11:0] pos,
                                            input logic [11:0] off,
                                            input logic [11:0] stop);
        logic [3:0]  k;
        logic [11:0] b;
        k = 4'h0;
        for (int i = 0; i < 4; i++) begin
            b    = pos + 12'(i);
            k[i] = (b >= off) && (b < stop);
        end
        return k;
    endfunction : txp_keep

    function automatic logic [11:0] txp_align_mask(input logic [1:0] code);
        case (code)
            ALIGN_16: return MASK_16;
            ALIGN_32: return MASK_32;
            default:  return MASK_4;  // reserved code treated as dword alignment
        endcase
    endfunction : txp_align_mask

    logic        aw_hs;
    logic        w_hs;
    logic        ar_hs;
    logic        wr_go;
    logic        out_hs;
    logic        dq_push;
    logic        sq_push;
    logic        sq_pop;
    logic        set_err;
    logic        set_done;
    logic [31:0] wd;
    logic [11:0] off;
    logic [11:0] stop;
    logic [11:0] end_al;
    logic [11:0] amask;
    logic [3:0]  keep;
    logic [11:0] nbytes;
    logic        buf_end;
    logic        is_last;
    logic        len_bad;
    logic [DQ_W-1:0] entry;
    logic [DQ_W-1:0] head;

    assign head                  = q.dq[q.dq_rd];
    assign s_axi_awready         = !q.aw_have && !q.bvalid;
    assign s_axi_wready          = !q.w_have && !q.bvalid;
    assign s_axi_bvalid          = q.bvalid;
    assign s_axi_bresp           = q.bresp;
    assign s_axi_arready         = !q.rvalid;
    assign s_axi_rvalid          = q.rvalid;
    assign s_axi_rdata           = q.rdata;
    assign s_axi_rresp           = q.rresp;
    assign tx_out_valid          = (q.dq_cnt != '0);
    assign tx_out_data           = head[31:0];
    assign tx_out_keep           = head[E_KEEP_LO+3:E_KEEP_LO];
    assign tx_out_last           = head[E_LAST];
    assign tx_error_flag         = q.err_flag;
    assign tx_buffer_loaded_flag = q.done_flag;
    assign tx_status_level_hit   = (q.level != '0) && (q.sq_cnt >= q.level);

    always_comb begin
        d        = q;
        aw_hs    = s_axi_awvalid && s_axi_awready;
        w_hs     = s_axi_wvalid && s_axi_wready;
        ar_hs    = s_axi_arvalid && s_axi_arready;
        wr_go    = q.aw_have && q.w_have && !q.bvalid;
        wd       = q.wdata;
        dq_push  = 1'b0;
        sq_push  = 1'b0;
        sq_pop   = 1'b0;
        set_err  = 1'b0;
        set_done = 1'b0;
        len_bad  = 1'b0;
        is_last  = q.cmd_a[A_LAST];
        off      = {7'h00, q.cmd_a[A_OFF_HI:A_OFF_LO]};
        stop     = off + {1'b0, q.cmd_a[A_SIZE_HI:0]};
        amask    = txp_align_mask(q.cmd_a[A_ALIGN_HI:A_ALIGN_LO]);
        end_al   = (stop + amask) & ~amask;
        keep     = txp_keep(q.pos, off, stop);
        nbytes   = 12'(keep[0]) + 12'(keep[1]) + 12'(keep[2]) + 12'(keep[3]);
        buf_end  = (q.pos + 12'h004) >= end_al;
        entry    = '0;
        // drain toward the engine stalls while the status queue is full
        out_hs   = tx_out_valid && tx_out_ready && (q.sq_cnt != (SQ_AW+1)'(SQ_DEPTH));

        if (aw_hs) begin
            d.aw_have = 1'b1;
            d.awaddr  = s_axi_awaddr;
        end
        if (w_hs) begin
            d.w_have = 1'b1;
            d.wdata  = s_axi_wdata;
            d.wstrb  = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end

        if (wr_go) begin
            d.aw_have = 1'b0;
            d.w_have  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = RESP_OKAY;
            case ({q.awaddr[ADDR_W-1:2], 2'b00})
                REG_DATA_PORT: begin
                    if (q.dq_cnt == (DQ_AW+1)'(DQ_DEPTH)) begin
                        set_err = 1'b1;
                    end else begin
                        case (q.st)
                            PS_CMD_A: begin
                                d.cmd_a = wd;
                                d.st    = PS_CMD_B;
                            end
                            PS_CMD_B: begin
                                d.st  = PS_DATA;
                                d.pos = 12'h000;
                                if (q.cmd_a[A_FIRST]) begin
                                    d.first_b   = wd;
                                    d.pkt_err   = 1'b0;
                                    d.pkt_bytes = 12'h000;
                                end else if (wd != q.first_b) begin
                                    d.pkt_err = 1'b1;
                                    set_err   = 1'b1;
                                end
                            end
                            PS_DATA: begin
                                d.pos       = q.pos + 12'h004;
                                d.pkt_bytes = q.pkt_bytes + nbytes;
                                len_bad     = is_last && buf_end
                                              && (d.pkt_bytes
                                                  != {1'b0, q.first_b[B_LEN_HI:0]});
                                if (len_bad) begin
                                    set_err = 1'b1;
                                end
                                // offset and pad dwords enter the queue only as the closing dword of a last buffer
                                dq_push = (keep != 4'h0) || (is_last && buf_end);
                                entry[31:0]                   = wd;
                                entry[E_KEEP_LO+3:E_KEEP_LO] = keep;
                                entry[E_LAST]                = is_last && buf_end;
                                entry[E_TAG_LO+15:E_TAG_LO]  = q.first_b[B_TAG_HI:B_TAG_LO];
                                entry[E_ERR]                 = q.pkt_err || len_bad;
                                if (buf_end) begin
                                    d.st     = PS_CMD_A;
                                    set_done = q.cmd_a[A_IRQ];
                                end
                            end
                            default: d.st = PS_CMD_A;
                        endcase
                    end
                end
                REG_FLAGS: begin
                    if (q.wstrb[0]) begin
                        // write one to clear; a same-cycle set still wins below
                        if (wd[FLG_ERR]) begin
                            d.err_flag = 1'b0;
                        end
                        if (wd[FLG_LOADED]) begin
                            d.done_flag = 1'b0;
                        end
                    end
                end
                REG_LEVEL: begin
                    if (q.wstrb[0]) begin
                        d.level = wd[SQ_AW:0];
                    end
                end
                REG_SPACE_INFO, REG_STATUS_POP: d.bresp = RESP_OKAY;
                default: d.bresp = RESP_SLVERR;
            endcase
        end

        if (set_err) begin
            d.err_flag = 1'b1;
        end
        if (set_done) begin
            d.done_flag = 1'b1;
        end

        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (ar_hs) begin
            d.rvalid = 1'b1;
            d.rresp  = RESP_OKAY;
            d.rdata  = 32'h0000_0000;
            case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
                REG_SPACE_INFO: begin
                    // free dwords low, waiting status words above
                    d.rdata[15:0]  = 16'((DQ_AW+1)'(DQ_DEPTH) - q.dq_cnt);
                    d.rdata[23:16] = 8'(q.sq_cnt);
                end
                REG_FLAGS: begin
                    d.rdata[FLG_ERR]    = q.err_flag;
                    d.rdata[FLG_LOADED] = q.done_flag;
                    d.rdata[FLG_LEVEL]  = tx_status_level_hit;
                end
                REG_STATUS_POP: begin
                    if (q.sq_cnt != '0) begin
                        d.rdata = q.sq[q.sq_rd];
                        sq_pop  = 1'b1;
                    end
                end
                REG_LEVEL: d.rdata[SQ_AW:0] = q.level;
                REG_DATA_PORT: d.rdata = 32'h0000_0000;
                default: d.rresp = RESP_SLVERR;
            endcase
        end

        if (dq_push) begin
            d.dq[q.dq_wr] = entry;
            d.dq_wr       = q.dq_wr + DQ_AW'(1);
        end
        if (out_hs) begin
            d.dq_rd = q.dq_rd + DQ_AW'(1);
            sq_push = head[E_LAST];
        end
        d.dq_cnt = q.dq_cnt + (DQ_AW+1)'(dq_push) - (DQ_AW+1)'(out_hs);

        if (sq_push) begin
            // tag high, error summary below it
            d.sq[q.sq_wr] = {head[E_TAG_LO+15:E_TAG_LO], head[E_ERR], 15'h0000};
            d.sq_wr       = q.sq_wr + SQ_AW'(1);
        end
        if (sq_pop) begin
            d.sq_rd = q.sq_rd + SQ_AW'(1);
        end
        d.sq_cnt = q.sq_cnt + (SQ_AW+1)'(sq_push) - (SQ_AW+1)'(sq_pop);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q       <= '0;
            q.st    <= PS_CMD_A;
            q.bresp <= RESP_OKAY;
            q.rresp <= RESP_OKAY;
        end else begin
            q <= d;
        end
    end

endmodule : txp_cmd_parser
`default_nettype wire

// ---- verif/txp_chk.sv ----
// concurrent checks on the parser's bus handshakes, stream and flags
// assumes bind onto txp_cmd_parser, one clock, synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module txp_chk (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    // stream and flags
    input wire logic        tx_out_valid,
    input wire logic        tx_out_ready,
    input wire logic [31:0] tx_out_data,
    input wire logic [3:0]  tx_out_keep,
    input wire logic        tx_out_last,
    input wire logic        tx_error_flag,
    input wire logic        tx_buffer_loaded_flag,
    input wire logic        tx_status_level_hit
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_b_after;
        // both halves are held one cycle before the answer is registered
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_b_after: assert property (p_b_after) else $error("write answer missing");
    property p_w_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_w_block: assert property (p_w_block) else $error("write taken during answer");
    property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_r_answer: assert property (p_r_answer) else $error("read answer missing");
    property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar_block: assert property (p_ar_block) else $error("read taken during answer");
    // error and loaded flags may only drop on the edge that completes a register write
    property p_err_hold; $fell(tx_error_flag) |-> $rose(s_axi_bvalid); endproperty
    a_err_hold: assert property (p_err_hold) else $error("error flag lost");
    property p_ld_hold; $fell(tx_buffer_loaded_flag) |-> $rose(s_axi_bvalid); endproperty
    a_ld_hold: assert property (p_ld_hold) else $error("loaded flag lost");
    property p_out_hold;
        tx_out_valid && !tx_out_ready |=> tx_out_valid && $stable(tx_out_data)
            && $stable(tx_out_keep) && $stable(tx_out_last);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("stream word changed");
    property p_keep_last; tx_out_valid && !tx_out_last |-> tx_out_keep != 4'h0; endproperty
    a_keep_last: assert property (p_keep_last) else $error("empty word mid packet");
    property p_lvl_hold; $fell(tx_status_level_hit) |-> s_axi_rvalid || $rose(s_axi_bvalid); endproperty
    a_lvl_hold: assert property (p_lvl_hold) else $error("level hit lost");
    c_last: cover property (tx_out_valid && tx_out_ready && tx_out_last);
    c_err: cover property ($rose(tx_error_flag));
    c_lvl: cover property ($rose(tx_status_level_hit));
endmodule : txp_chk
bind txp_cmd_parser txp_chk u_chk (.*);
`default_nettype wire

// ---- verif/txp_engine_model.sv ----
// transmit engine stand-in: takes stream words with random stalls
// assumes the bench raises hold to stop it draining
`timescale 1ns/1ns
`default_nettype none
module txp_engine_model (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // control and stream handshake
    input  wire logic hold,
    output logic      tx_out_ready
);
    integer seed = 32'hA5161D6D;
    logic   rdy_q = 1'b0;
    assign tx_out_ready = rdy_q;
    always @(posedge aclk) begin
        if (!aresetn || hold) begin
            rdy_q <= 1'b0;
        end else begin
            rdy_q <= ($random(seed) % 3) != 0;
        end
    end
endmodule : txp_engine_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench for the transmit command parser
// assumes txp_pkg, the checker bind and the engine model are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import txp_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, hold = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, tx_out_data, m;
    logic [3:0] s_axi_wstrb = 4'hF, tx_out_keep;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic tx_out_valid, tx_out_ready, tx_out_last;
    logic tx_error_flag, tx_buffer_loaded_flag, tx_status_level_hit;
    integer seed = 32'hA5161D6D;
    int n_mismatch = 0, compares = 0;
    logic [33:0] rd_q[$];
    logic [1:0] wr_q[$];
    logic [36:0] out_q[$], e;
    txp_cmd_parser u_dut (.*);
    txp_engine_model u_eng (.*);
    always #5 aclk = ~aclk;
    task automatic tally_and_finish;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 400) begin
            n_mismatch++;
            $display("BAD %0t wait ran out", $time);
            tally_and_finish();
        end
    endtask : tick
    task automatic cmp_rd(input logic [33:0] got, exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t read got %h exp %h", $time, got, exp);
        end
    endtask : cmp_rd
    task automatic cmp_wr(input logic [1:0] got, exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t write answer got %h exp %h", $time, got, exp);
        end
    endtask : cmp_wr
    task automatic cmp_word(input logic [36:0] got, exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t word got %h exp %h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic cmp_pin(input logic [2:0] got, exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t flag pins got %h exp %h", $time, got, exp);
        end
    endtask : cmp_pin
    task automatic axw(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       input logic [1:0] r = RESP_OKAY);
        int n;
        n = 0;
        wr_q.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            tick(n);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
    endtask : axw
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      input logic [1:0] r = RESP_OKAY);
        int n;
        n = 0;
        rd_q.push_back({r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do tick(n); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do tick(n); while (!s_axi_rvalid);
    endtask : rd
    // one buffer: command pair, then payload padded to the end boundary
    task automatic send(input logic [31:0] b, input int off, sz, input logic [1:0] al,
                        input logic fst, lst);
        int x, n;
        logic [3:0] k;
        logic [31:0] d;
        x = off + sz;
        if (al == 2'h1) x = (x + 15) / 16 * 16;
        else if (al == 2'h2) x = (x + 31) / 32 * 32;
        else x = (x + 3) / 4 * 4;
        n = (x < 4) ? 1 : x / 4;
        axw(REG_DATA_PORT, {1'b1, 5'h0, al, 3'h0, off[4:0], 2'h0, fst, lst, 1'b0, sz[10:0]});
        axw(REG_DATA_PORT, b);
        for (int j = 0; j < n; j++) begin
            d = $random(seed);
            for (int i = 0; i < 4; i++) k[i] = (4 * j + i >= off) && (4 * j + i < off + sz);
            if (k != 4'h0 || (j == n - 1 && lst)) out_q.push_back({j == n - 1 && lst, k, d});
            axw(REG_DATA_PORT, d);
        end
    endtask : send
    // flag register and the flag pins must agree with the expectation
    task automatic flags(input logic [2:0] x);
        rd(REG_FLAGS, {29'h0, x});
        cmp_pin({tx_status_level_hit, tx_buffer_loaded_flag, tx_error_flag}, x);
    endtask : flags
    task automatic drain;
        int n;
        n = 0;
        while (out_q.size() != 0) tick(n);
    endtask : drain
    task automatic fin(input logic [15:0] t, input logic err);
        drain();
        rd(REG_STATUS_POP, {t, err, 15'h0});
    endtask : fin
    always @(posedge aclk) begin
        if (aresetn && s_axi_rvalid && s_axi_rready) begin
            cmp_rd({s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
        end
        if (aresetn && s_axi_bvalid && s_axi_bready) begin
            cmp_wr(s_axi_bresp, wr_q.pop_front());
        end
        if (aresetn && tx_out_valid && tx_out_ready) begin
            e = out_q.pop_front();
            m = {{8{e[35]}}, {8{e[34]}}, {8{e[33]}}, {8{e[32]}}};
            cmp_word({tx_out_last, tx_out_keep, tx_out_data & m}, {e[36:32], e[31:0] & m});
        end
    end
    initial begin
        logic [15:0] t, u;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(REG_SPACE_INFO, 32'h10);
        flags(3'h0);
        rd(8'h14, 32'h0, RESP_SLVERR);
        axw(8'h14, 32'h0, RESP_SLVERR);
        axw(REG_LEVEL, 32'h1);
        rd(REG_LEVEL, 32'h1);
        t = $random(seed);
        send({t, 5'h0, 11'd5}, 2, 5, 2'h0, 1'b1, 1'b1);
        drain();
        flags(3'h6);
        rd(REG_SPACE_INFO, 32'h0001_0010);
        rd(REG_STATUS_POP, {t, 16'h0});
        flags(3'h2);
        axw(REG_FLAGS, 32'h3);
        flags(3'h0);
        for (int a = 0; a < 4; a++) begin
            t = $random(seed);
            send({t, 5'h0, 11'(3 * a + 2)}, a, 3 * a + 2, 2'(a), 1'b1, 1'b1);
            fin(t, 1'b0);
        end
        t = $random(seed);
        u = t ^ 16'h0100;
        send({t, 5'h0, 11'd7}, 0, 4, 2'h0, 1'b1, 1'b0);
        send({u, 5'h0, 11'd7}, 1, 3, 2'h0, 1'b0, 1'b1);
        fin(t, 1'b1);
        flags(3'h3);
        axw(REG_FLAGS, 32'h3);
        send({t, 5'h0, 11'd6}, 0, 4, 2'h0, 1'b1, 1'b1);
        fin(t, 1'b1);
        flags(3'h3);
        axw(REG_FLAGS, 32'h3);
        hold <= 1'b1;
        send({t, 5'h0, 11'd64}, 0, 64, 2'h0, 1'b1, 1'b0);
        rd(REG_SPACE_INFO, 32'h0);
        axw(REG_DATA_PORT, 32'h0);
        flags(3'h3);
        hold <= 1'b0;
        drain();
        send({t, 5'h0, 11'd64}, 0, 0, 2'h0, 1'b0, 1'b1);
        drain();
        flags(3'h7);
        // reset in mid-run must empty both queues and drop every flag
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        flags(3'h0);
        rd(REG_SPACE_INFO, 32'h10);
        rd(REG_LEVEL, 32'h0);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
